// ===== core/hbs_regs.vh
// Constants of the holding brake sequencer: setting addresses, field
// positions, reset values, groups and timing counts.
// Assumes the includer is a Verilog or SystemVerilog design or bench file.
`ifndef HBS_REGS_VH
`define HBS_REGS_VH

// ********************************************************************
// Address layout: {group[2:0], index[3:0], 2'b00}
// ********************************************************************
`define HBS_ADDR_W        9
`define HBS_GRP_MSB       8
`define HBS_GRP_LSB       6
`define HBS_IDX_MSB       5
`define HBS_IDX_LSB       2
`define HBS_DATA_W        16

// Setting groups
`define HBS_GRP_MONITOR   3'h0
`define HBS_GRP_BASIC     3'h1
`define HBS_GRP_EXTEND    3'h2
`define HBS_GRP_COMM      3'h3
`define HBS_GRP_DIAG      3'h4

// ********************************************************************
// Setting byte addresses
// ********************************************************************
`define HBS_A_IDENT       9'h000
`define HBS_A_STATUS      9'h004
`define HBS_A_REL_DLY     9'h040
`define HBS_A_ENG_DLY     9'h044
`define HBS_A_SPD_THR     9'h048
`define HBS_A_BRK_CFG     9'h080
`define HBS_A_COMM_SCR    9'h0C0
`define HBS_A_REJ_CNT     9'h100
`define HBS_A_ENG_CAUSE   9'h104

// ********************************************************************
// Reset values and fields
// ********************************************************************
`define HBS_IDENT_VAL     16'h00A5 // Arbitrary value
`define HBS_REL_DLY_RST   16'h0000
`define HBS_ENG_DLY_RST   16'h0000
`define HBS_SPD_THR_RST   16'h0014
`define HBS_BRK_CFG_RST   16'h0001
`define HBS_COMM_SCR_RST  16'h0000
`define HBS_CFG_AUTO_BIT  0
`define HBS_ST_BRK_BIT    0
`define HBS_ST_SEN_BIT    1
`define HBS_ST_FSM_LSB    2
`define HBS_ST_PEND_BIT   4
`define HBS_CAUSE_SPD     2'h1
`define HBS_CAUSE_TMO     2'h2

// ********************************************************************
// Timing: delay settings count in milliseconds
// ********************************************************************
`define HBS_CLK_NS        20
`define HBS_MS_NS         1000000
`define HBS_CYC_PER_MS    (`HBS_MS_NS / `HBS_CLK_NS)

`endif

// ===== core/hbs_delay_cnt.v
// Millisecond delay timer used for the brake release and engage delays.
// Assumes start is a one-cycle pulse and setting is stable while running.
`timescale 1ns/1ps

module hbs_delay_cnt #(
  parameter CYC_PER_MS = 50000,
  parameter PRE_W      = 16,
  parameter DLY_W      = 16
) (
  // Clock and reset
  input  wire             core_clk_i,
  input  wire             rst_i,
  // Control
  input  wire             start_i,
  input  wire             cancel_i,
  input  wire [DLY_W-1:0] setting_i,
  // Status
  output wire             busy_o,
  output wire             done_o
);

  // Full-width last count, cut to the prescaler on purpose
  localparam [31:0]      PRE_LAST_W = CYC_PER_MS - 1;
  localparam [PRE_W-1:0] PRE_LAST   = PRE_LAST_W[PRE_W-1:0];

  reg             run_r;
  reg [PRE_W-1:0] pre_r;
  reg [DLY_W-1:0] ms_r;

  // Expiry once whole milliseconds reach the setting
  assign done_o = run_r && (ms_r >= setting_i);
  assign busy_o = run_r;

  // ******************************************************************
  // Prescaler and millisecond count
  // ******************************************************************
  always @(posedge core_clk_i) begin
    if (rst_i || cancel_i) begin
      run_r <= 1'b0;
      pre_r <= {PRE_W{1'b0}};
      ms_r  <= {DLY_W{1'b0}};
    end else if (start_i) begin
      run_r <= 1'b1;
      pre_r <= {PRE_W{1'b0}};
      ms_r  <= {DLY_W{1'b0}};
    end else if (done_o) begin
      run_r <= 1'b0; // One expiry per start
    end else if (run_r) begin
      if (pre_r == PRE_LAST) begin
        pre_r <= {PRE_W{1'b0}};
        ms_r  <= ms_r + {{(DLY_W-1){1'b0}}, 1'b1};
      end else begin
        pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ===== core/hbs_brake_seq.v
// Holding brake sequencer: drives the brake release output from the
// servo enable input, with release/engage delays and speed threshold,
// plus the setting store with its access attributes.
// Assumes all inputs synchronous to core_clk_i; motor speed is an
// unsigned magnitude in the same unit as the threshold setting.
//
// Summary of operation
// - Output low: brake engaged, motor locked
// - Output high: brake released, motor free
// - Separate release and engage delay settings
// - Engage at delay expiry while still fast
// - Engage early once speed drops below threshold
// - Brake engages only after servo disabled or at a drive restart
// - Read-only settings ignore writes
// - Locked settings reject writes while servo on
// - Restart settings apply after next restart
// - Volatile settings return to default
// - Settings in five numbered groups
`timescale 1ns/1ps
`include "hbs_regs.vh"

module hbs_brake_seq #(
  parameter CYC_PER_MS = `HBS_CYC_PER_MS,
  parameter IDENT      = `HBS_IDENT_VAL // Arbitrary identity value
) (
  // Clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  // Drive restart that keeps non-volatile settings
  input  wire                   drive_restart_i,
  // Servo and motor
  input  wire                   servo_enable_in_i,
  input  wire [`HBS_DATA_W-1:0] motor_speed_i,
  // Setting port
  input  wire [`HBS_ADDR_W-1:0] reg_addr_i,
  input  wire [`HBS_DATA_W-1:0] reg_wdata_i,
  input  wire                   reg_we_i,
  input  wire                   reg_re_i,
  output reg  [`HBS_DATA_W-1:0] reg_rdata_o,
  // Brake relay
  output wire                   brake_release_out_o
);

  // ******************************************************************
  // Sequencer states
  // ******************************************************************
  // Locked: release output low, waiting for servo on.
  // Release wait: release delay running; servo off aborts it.
  // Released: motor free while the servo holds it.
  // Engage wait: engage delay running, speed watched every cycle.
  localparam [1:0] ST_LOCKED   = 2'b00;
  localparam [1:0] ST_REL_WAIT = 2'b01;
  localparam [1:0] ST_RELEASED = 2'b10;
  localparam [1:0] ST_ENG_WAIT = 2'b11;

  // Counter increment, sized to the counter
  localparam [15:0] ONE16 = 16'h0001;

  // Sequencer registers and strobes
  reg  [1:0]             state_r;
  reg  [1:0]             state_nxt;
  reg                    brake_r;
  reg                    brake_nxt;
  reg                    sen_q_r;
  reg                    rel_start;
  reg                    eng_start;
  reg  [1:0]             cause_r;

  // Settings; config keeps a stored copy for software and an active
  // copy that the sequencer uses
  reg  [`HBS_DATA_W-1:0] rel_dly_r;
  reg  [`HBS_DATA_W-1:0] eng_dly_r;
  reg  [`HBS_DATA_W-1:0] spd_thr_r;
  reg  [`HBS_DATA_W-1:0] cfg_store_r;
  reg  [`HBS_DATA_W-1:0] cfg_act_r;
  reg  [`HBS_DATA_W-1:0] comm_scr_r;
  reg  [`HBS_DATA_W-1:0] rej_cnt_r;

  // Decode and timer nets
  wire                   sen_fall;
  wire                   rel_done;
  wire                   eng_done;
  wire                   slow;
  wire                   auto_en;
  wire                   cfg_pend;
  wire                   wr_locked;
  wire                   wr_rej;
  wire [2:0]             acc_grp;

  // Servo edge and speed compare; equal speed is not slow, so it
  // waits on the engage timer.
  assign sen_fall = !servo_enable_in_i && sen_q_r;
  assign slow     = (motor_speed_i < spd_thr_r);
  assign auto_en  = cfg_act_r[`HBS_CFG_AUTO_BIT];
  assign cfg_pend = (cfg_store_r != cfg_act_r);
  assign acc_grp  = reg_addr_i[`HBS_GRP_MSB:`HBS_GRP_LSB];

  // Register high releases, low engages
  assign brake_release_out_o = brake_r;

  // ******************************************************************
  // Delay timers
  // ******************************************************************
  // Each timer is cleared once its wait state is left, so a stale
  // expiry cannot leak into a later sequence. Restart clears both.
  // Release delay timer
  hbs_delay_cnt #(
    .CYC_PER_MS (CYC_PER_MS),
    .PRE_W      (16),
    .DLY_W      (`HBS_DATA_W)
  ) u_rel_cnt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i || drive_restart_i),
    .start_i    (rel_start),
    .cancel_i   (state_r != ST_REL_WAIT && !rel_start),
    .setting_i  (rel_dly_r),
    .busy_o     (),
    .done_o     (rel_done)
  );

  // Engage delay timer
  hbs_delay_cnt #(
    .CYC_PER_MS (CYC_PER_MS),
    .PRE_W      (16),
    .DLY_W      (`HBS_DATA_W)
  ) u_eng_cnt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i || drive_restart_i),
    .start_i    (eng_start),
    .cancel_i   (state_r != ST_ENG_WAIT && !eng_start),
    .setting_i  (eng_dly_r),
    .busy_o     (),
    .done_o     (eng_done)
  );

  // ******************************************************************
  // Brake sequencer
  // ******************************************************************
  // Next state; here the release output only falls in ST_ENG_WAIT, which
  // is reached only with servo off, so only a restart can bite a driven
  // motor. The servo level is tested first in both wait states, so a
  // returning servo always beats a pending timer.
  always @* begin
    state_nxt = state_r;
    brake_nxt = brake_r;
    rel_start = 1'b0;
    eng_start = 1'b0;
    case (state_r)
      ST_LOCKED: begin
        brake_nxt = 1'b0;
        if (servo_enable_in_i) begin
          state_nxt = ST_REL_WAIT;
          rel_start = 1'b1;
        end
      end
      ST_REL_WAIT: begin
        if (!servo_enable_in_i) begin
          state_nxt = ST_LOCKED;
        end else if (rel_done || !auto_en) begin
          state_nxt = ST_RELEASED;
          brake_nxt = 1'b1;
        end
      end
      ST_RELEASED: begin
        brake_nxt = 1'b1;
        if (sen_fall || !servo_enable_in_i) begin
          state_nxt = ST_ENG_WAIT;
          eng_start = 1'b1;
        end
      end
      ST_ENG_WAIT: begin
        if (servo_enable_in_i) begin
          state_nxt = ST_RELEASED; // Servo back on, keep released
        end else if (slow || !auto_en) begin
          state_nxt = ST_LOCKED;
          brake_nxt = 1'b0;
        end else if (eng_done) begin
          state_nxt = ST_LOCKED;
          brake_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_LOCKED;
        brake_nxt = 1'b0;
      end
    endcase
  end

  // State, output and engage cause registers
  // Cause notes speed if slow when the brake closed, else timeout.
  // Restart returns the sequencer to locked, like power-on.
  always @(posedge core_clk_i) begin
    if (rst_i || drive_restart_i) begin
      state_r <= ST_LOCKED;
      brake_r <= 1'b0;
      sen_q_r <= 1'b0;
      cause_r <= 2'b00;
    end else begin
      state_r <= state_nxt;
      brake_r <= brake_nxt;
      sen_q_r <= servo_enable_in_i;
      if (state_r == ST_ENG_WAIT && state_nxt == ST_LOCKED) begin
        cause_r <= slow ? `HBS_CAUSE_SPD : `HBS_CAUSE_TMO;
      end
    end
  end

  // ******************************************************************
  // Setting writes
  // ******************************************************************
  // Delay settings are locked while the servo is on; a write then is
  // dropped and counted so software can see it was refused.
  // Other writable settings accept writes whatever the servo level.
  assign wr_locked = servo_enable_in_i &&
                     (reg_addr_i == `HBS_A_REL_DLY ||
                      reg_addr_i == `HBS_A_ENG_DLY);
  assign wr_rej    = reg_we_i && wr_locked;

  // Non-volatile settings: kept across a drive restart
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rel_dly_r   <= `HBS_REL_DLY_RST;
      eng_dly_r   <= `HBS_ENG_DLY_RST;
      cfg_store_r <= `HBS_BRK_CFG_RST;
      comm_scr_r  <= `HBS_COMM_SCR_RST;
    end else if (reg_we_i && !wr_locked) begin
      case (reg_addr_i)
        `HBS_A_REL_DLY:  rel_dly_r   <= reg_wdata_i;
        `HBS_A_ENG_DLY:  eng_dly_r   <= reg_wdata_i;
        `HBS_A_BRK_CFG:  cfg_store_r <= reg_wdata_i;
        `HBS_A_COMM_SCR: comm_scr_r  <= reg_wdata_i;
        default: begin
          // Read-only and unmapped addresses keep their value
          rel_dly_r <= rel_dly_r;
        end
      endcase
    end
  end

  // Volatile threshold: default again after every restart
  // Never locked: a new threshold moves the early engage; the engage delay still bounds the wait.
  always @(posedge core_clk_i) begin
    if (rst_i || drive_restart_i) begin
      spd_thr_r <= `HBS_SPD_THR_RST;
    end else if (reg_we_i && reg_addr_i == `HBS_A_SPD_THR) begin
      spd_thr_r <= reg_wdata_i;
    end
  end

  // Active configuration only follows the stored one at a restart,
  // so a change cannot upset a motion in progress.
  // Power-on reset loads the default, not the stored copy.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_act_r <= `HBS_BRK_CFG_RST;
    end else if (drive_restart_i) begin
      cfg_act_r <= cfg_store_r;
    end
  end

  // Refused write counter, saturating
  // Saturates rather than wraps, so a long burst is never hidden.
  always @(posedge core_clk_i) begin
    if (rst_i || drive_restart_i) begin
      rej_cnt_r <= 16'h0000;
    end else if (wr_rej && rej_cnt_r != 16'hFFFF) begin
      rej_cnt_r <= rej_cnt_r + ONE16;
    end
  end

  // ******************************************************************
  // Setting reads
  // ******************************************************************
  // Read data stand one cycle after the strobe, zero otherwise;
  // unmapped addresses and groups above diagnosis read as zero.
  // Status packs pending config, state, servo level and brake level.
  // Identity is a fixed parameter; writes to it fall through.
  always @(posedge core_clk_i) begin
    if (rst_i || !reg_re_i || acc_grp > `HBS_GRP_DIAG) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_addr_i)
        `HBS_A_IDENT:     reg_rdata_o <= IDENT;
        `HBS_A_STATUS:    reg_rdata_o <= {11'h000, cfg_pend,
                                          state_r,
                                          servo_enable_in_i,
                                          brake_r};
        `HBS_A_REL_DLY:   reg_rdata_o <= rel_dly_r;
        `HBS_A_ENG_DLY:   reg_rdata_o <= eng_dly_r;
        `HBS_A_SPD_THR:   reg_rdata_o <= spd_thr_r;
        `HBS_A_BRK_CFG:   reg_rdata_o <= cfg_store_r;
        `HBS_A_COMM_SCR:  reg_rdata_o <= comm_scr_r;
        `HBS_A_REJ_CNT:   reg_rdata_o <= rej_cnt_r;
        `HBS_A_ENG_CAUSE: reg_rdata_o <= {14'h0000, cause_r};
        default:          reg_rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule

// ===== tb/hbs_seq_chk_assertions.sv
// Checker of the brake sequencer, seen from its ports only.
// Assumes binding onto hbs_brake_seq and one clock domain.
`timescale 1ns/1ps
`include "hbs_regs.vh"

module hbs_seq_chk #(
  parameter IDENT = 16'h0000
) (
  // Clock and resets
  input wire                   core_clk_i,
  input wire                   rst_i,
  input wire                   drive_restart_i,
  // Servo and motor
  input wire                   servo_enable_in_i,
  input wire [`HBS_DATA_W-1:0] motor_speed_i,
  // Setting port
  input wire [`HBS_ADDR_W-1:0] reg_addr_i,
  input wire [`HBS_DATA_W-1:0] reg_wdata_i,
  input wire                   reg_we_i,
  input wire                   reg_re_i,
  input wire [`HBS_DATA_W-1:0] reg_rdata_o,
  input wire                   brake_release_out_o
);
  // ******
  // Helpers
  // ******
  // Threshold shadow; volatile, so restart drops it
  reg [`HBS_DATA_W-1:0] thr_r;
  always @(posedge core_clk_i) begin
    if (rst_i || drive_restart_i)
      thr_r <= `HBS_SPD_THR_RST;
    else if (reg_we_i && reg_addr_i == `HBS_A_SPD_THR)
      thr_r <= reg_wdata_i;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Servo off held, brake open, motor already slow
  sequence s_off_slow;
    brake_release_out_o && !servo_enable_in_i &&
      !$past(servo_enable_in_i) && motor_speed_i < thr_r;
  endsequence
  sequence s_locks_soon;
    ##[1:3] !brake_release_out_o;
  endsequence

  // Engage early beats the timer
  chk_speed_lock: assert property (s_off_slow |-> s_locks_soon)
    else $error("brake open after speed fell");
  chk_engage_after: assert property ($fell(brake_release_out_o) |->
    !$past(servo_enable_in_i) || $past(drive_restart_i))
    else $error("brake engaged while servo on");
  chk_no_rise_off: assert property (!brake_release_out_o &&
    !servo_enable_in_i |=> !brake_release_out_o)
    else $error("brake released while servo off");
  chk_hold_open: assert property (brake_release_out_o &&
    servo_enable_in_i && !drive_restart_i |=> brake_release_out_o)
    else $error("brake dropped while servo on");
  chk_restart_lock: assert property (drive_restart_i |=>
    !brake_release_out_o)
    else $error("brake open after restart");
  chk_ro_ident: assert property (reg_re_i &&
    reg_addr_i == `HBS_A_IDENT |=> reg_rdata_o == IDENT)
    else $error("identity read wrong");
  chk_group_hole: assert property (reg_re_i &&
    reg_addr_i[8:6] > 3'h4 |=> reg_rdata_o == 16'h0000)
    else $error("missing group read not zero");
  chk_rdata_idle: assert property (!$past(reg_re_i) |->
    reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
endmodule

bind hbs_brake_seq hbs_seq_chk #(.IDENT(IDENT)) u_chk (
  .core_clk_i         (core_clk_i),
  .rst_i              (rst_i),
  .drive_restart_i    (drive_restart_i),
  .servo_enable_in_i  (servo_enable_in_i),
  .motor_speed_i      (motor_speed_i),
  .reg_addr_i         (reg_addr_i),
  .reg_wdata_i        (reg_wdata_i),
  .reg_we_i           (reg_we_i),
  .reg_re_i           (reg_re_i),
  .reg_rdata_o        (reg_rdata_o),
  .brake_release_out_o(brake_release_out_o)
);

// ===== tb/hbs_motor_model.sv
// Motor and relay model: speed follows brake and servo state.
// Assumes the bench chooses the deceleration step per cycle.
`timescale 1ns/1ps

module hbs_motor_model (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        rst_i,
  // From controller and drive
  input  wire        servo_enable_in_i,
  input  wire        brake_release_out_i,
  input  wire [15:0] decel_step_i,
  // To drive
  output reg  [15:0] motor_speed_o
);
  // ******
  // Speed
  // ******
  // Held brake stops the shaft at once; worst case for timing
  always @(posedge core_clk_i) begin
    if (rst_i || !brake_release_out_i)
      motor_speed_o <= 16'h0000;
    else if (servo_enable_in_i)
      motor_speed_o <= 16'h0200;
    else if (motor_speed_o > decel_step_i)
      motor_speed_o <= motor_speed_o - decel_step_i;
    else
      motor_speed_o <= 16'h0000;
  end
endmodule

// ===== tb/tb_holding_brake_sequencer.sv
// Bench of the holding brake sequencer with a motor model.
// Assumes a 50 MHz clock and 4 cycles per millisecond.
`timescale 1ns/1ps
`include "hbs_regs.vh"

module tb_holding_brake_sequencer;
  localparam [15:0] ID  = 16'h3c5a; // Arbitrary identity value
  localparam        CPM = 4;
  reg         core_clk_i = 1'b0;
  reg         rst_i      = 1'b1;
  reg         restart    = 1'b0;
  reg         servo      = 1'b0;
  reg  [15:0] step       = 16'h0001;
  reg  [8:0]  addr       = 9'h000;
  reg  [15:0] wdata      = 16'h0000;
  reg         we         = 1'b0;
  reg         re         = 1'b0;
  reg         rd_q       = 1'b0;
  reg  [15:0] e;
  reg  [15:0] expq[$];
  reg  [31:0] seed       = 32'h69d0_9b17;
  wire [15:0] rdata;
  wire [15:0] speed;
  wire        brake;
  integer     mismatches = 0;
  integer     checks     = 0;
  integer     n;

  always #10 core_clk_i = ~core_clk_i;

  hbs_brake_seq #(.CYC_PER_MS(CPM), .IDENT(ID)) uut (
    .core_clk_i         (core_clk_i),
    .rst_i              (rst_i),
    .drive_restart_i    (restart),
    .servo_enable_in_i  (servo),
    .motor_speed_i      (speed),
    .reg_addr_i         (addr),
    .reg_wdata_i        (wdata),
    .reg_we_i           (we),
    .reg_re_i           (re),
    .reg_rdata_o        (rdata),
    .brake_release_out_o(brake)
  );
  hbs_motor_model u_motor (
    .core_clk_i         (core_clk_i),
    .rst_i              (rst_i),
    .servo_enable_in_i  (servo),
    .brake_release_out_i(brake),
    .decel_step_i       (step),
    .motor_speed_o      (speed)
  );

  // ******
  // Tasks
  // ******
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cmp(input string nm, input [15:0] x, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        mismatches = mismatches + 1;
        $display("Error %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task rng(input string nm, input integer lo, input integer hi);
    cmp(nm, 16'h0001, {15'h0000, (n >= lo && n <= hi)});
  endtask
  // Strobes stay up so transfers run back to back
  task wr(input [8:0] a, input [15:0] d);
    begin
      @(posedge core_clk_i);
      addr  <= a;
      wdata <= d;
      we    <= 1'b1;
      re    <= 1'b0;
    end
  endtask
  task rd(input [8:0] a, input [15:0] x);
    begin
      @(posedge core_clk_i);
      addr <= a;
      we   <= 1'b0;
      re   <= 1'b1;
      expq.push_back(x);
    end
  endtask
  task idle;
    begin
      @(posedge core_clk_i);
      we <= 1'b0;
      re <= 1'b0;
    end
  endtask
  // Bounded wait on the brake output, cycles left in n
  task wait_brake(input lvl, input integer lim);
    begin
      n = 0;
      while (brake !== lvl && n < lim) begin
        @(posedge core_clk_i);
        #1;
        n = n + 1;
      end
      if (brake !== lvl) begin
        mismatches = mismatches + 1;
        $display("Error brake wait expected %h seen %h", lvl, brake);
        report_and_stop;
      end
    end
  endtask

  // Read results land one cycle after the strobe
  always @(posedge core_clk_i) begin
    if (rd_q) begin
      e = 16'hxxxx;
      if (expq.size() > 0)
        e = expq.pop_front();
      cmp("rdata", e, rdata);
    end
    rd_q <= re;
  end

  // ******
  // Sequence
  // ******
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(`HBS_A_REL_DLY, `HBS_REL_DLY_RST);
    rd(`HBS_A_ENG_DLY, `HBS_ENG_DLY_RST);
    rd(`HBS_A_BRK_CFG, `HBS_BRK_CFG_RST);
    seed = xs(seed);
    wr(`HBS_A_IDENT, seed[15:0]);
    wr(`HBS_A_COMM_SCR, seed[31:16]);
    rd(`HBS_A_IDENT, ID);
    rd(`HBS_A_COMM_SCR, seed[31:16]);
    for (n = 5; n < 8; n = n + 1)
      rd({n[2:0], 6'h00}, 16'h0000);
    wr(`HBS_A_REL_DLY, 16'h0001);
    wr(`HBS_A_ENG_DLY, 16'h0003);
    idle;
    servo <= 1'b1;
    wait_brake(1'b1, 40);
    rng("release", 4, 9);
    wr(`HBS_A_REL_DLY, 16'h0007);
    rd(`HBS_A_REL_DLY, 16'h0001);
    rd(`HBS_A_REJ_CNT, 16'h0001);
    idle;
    servo <= 1'b0;
    wait_brake(1'b0, 40);
    rng("engage slow", 12, 17);
    rd(`HBS_A_ENG_CAUSE, {14'h0000, `HBS_CAUSE_TMO});
    idle;
    servo <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    servo <= 1'b0;
    for (n = 0; n < 12; n = n + 1) begin
      @(posedge core_clk_i);
      cmp("cancel hold", 16'h0000, {15'h0000, brake});
    end
    step  <= 16'h0200;
    servo <= 1'b1;
    cmp("cancel", 16'h0000, {15'h0000, brake});
    wait_brake(1'b1, 40);
    repeat (3) @(posedge core_clk_i);
    servo <= 1'b0;
    wait_brake(1'b0, 20);
    rng("engage fast", 1, 4);
    rd(`HBS_A_ENG_CAUSE, {14'h0000, `HBS_CAUSE_SPD});
    wr(`HBS_A_SPD_THR, 16'h0100);
    wr(`HBS_A_BRK_CFG, 16'h0000);
    rd(`HBS_A_SPD_THR, 16'h0100);
    rd(`HBS_A_BRK_CFG, 16'h0000);
    rd(`HBS_A_STATUS, 16'h0001 << `HBS_ST_PEND_BIT);
    idle;
    servo <= 1'b1;
    wait_brake(1'b1, 40);
    rng("cfg pending", 4, 9);
    @(posedge core_clk_i);
    servo <= 1'b0;
    wait_brake(1'b0, 20);
    @(posedge core_clk_i);
    restart <= 1'b1;
    @(posedge core_clk_i);
    restart <= 1'b0;
    rd(`HBS_A_SPD_THR, `HBS_SPD_THR_RST);
    rd(`HBS_A_REL_DLY, 16'h0001);
    idle;
    servo <= 1'b1;
    wait_brake(1'b1, 40);
    rng("cfg applied", 1, 3);
    repeat (2) @(posedge core_clk_i);
    report_and_stop;
  end
endmodule
